// file: lts_consts.svh
// constants for the loop telegram switch and spread transmitter
// Contract
// R1 - keep sending the current telegram repeatedly, back to back, without end
// R2 - on telegram change insert a constant all-zeros or all-ones run
// R3 - the filler run is at least 75 and at most 128 bits long
// R4 - switch-over may happen at any bit position of either telegram
// R5 - one of fifteen operational codes 0 to 14, each 472 chips long
// R6 - code number 15 is test only, never used operationally
// R7 - receiver accepts only messages spread with its handed code number; lts_loop_rx only flags rx_bad and still strobes every bit
// R8 - carrier is spread with the assigned code; receiver despreads with its own
// R9 - telegram bits go out at the rate they arrive from the source
// R10 - code number held stable while sending; one full code pass per bit
`ifndef LTS_CONSTS_SVH
`define LTS_CONSTS_SVH
`define LTS_FILL_MIN      8'd75
`define LTS_FILL_MAX      8'd128
`define LTS_FILL_DEFAULT  8'd100
`define LTS_CHIP_LEN      472
`define LTS_CODE_TEST     4'hf
`define LTS_CODE_LAST_OP  4'he
`endif

// file: lts_pkg.sv
// types for the loop telegram switch and spread transmitter
`default_nettype none
package lts_pkg;
    typedef enum logic [1:0] {
        LTS_IDLE,
        LTS_TELEGRAM,
        LTS_FILL
    } lts_state_t;
endpackage
`default_nettype wire

// file: lts_chip_if.sv
// interface between the framer and the chip spreader
`timescale 1ns/1ps
`default_nettype none
interface lts_chip_if;
    logic       bit_valid;
    logic       bit_value;
    logic       bit_ready;
    modport framer  (output bit_valid, output bit_value, input bit_ready);
    modport spreader(input bit_valid, input bit_value, output bit_ready);
endinterface
`default_nettype wire

// file: lts_spreader.sv
// direct-sequence spreader: one full code pass per data bit
`timescale 1ns/1ps
`default_nettype none
`include "lts_consts.svh"
module lts_spreader #(
    parameter int CHIP_LEN = `LTS_CHIP_LEN
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    lts_chip_if.spreader            cif,
    input  wire logic [CHIP_LEN-1:0] code_chips,
    output logic                    chip_out_ff,
    output logic                    chip_valid_ff,
    output logic                    bit_start_ff
);
    localparam int CW = $clog2(CHIP_LEN);
    localparam logic [CW-1:0] LAST = CW'(CHIP_LEN - 1);
    logic [CW-1:0] chip_idx_ff;
    logic          busy_ff;
    logic          cur_bit_ff;
    assign cif.bit_ready = !busy_ff || (chip_idx_ff == LAST);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_ff     <= 1'b0;
            chip_idx_ff <= '0;
            cur_bit_ff  <= 1'b0;
        end else if (cif.bit_valid && cif.bit_ready) begin
            busy_ff     <= 1'b1;
            chip_idx_ff <= '0;
            cur_bit_ff  <= cif.bit_value;
        end else if (busy_ff) begin
            if (chip_idx_ff == LAST) begin
                busy_ff <= 1'b0; // [R10]
            end else begin
                chip_idx_ff <= chip_idx_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chip_out_ff   <= 1'b0;
            chip_valid_ff <= 1'b0;
            bit_start_ff  <= 1'b0;
        end else begin
            chip_valid_ff <= busy_ff;
            bit_start_ff  <= busy_ff && (chip_idx_ff == '0);
            chip_out_ff   <= busy_ff & (cur_bit_ff ^ code_chips[chip_idx_ff]); // [R8]
        end
    end
endmodule
`default_nettype wire

// file: lts_framer.sv
// telegram repeater with filler insertion, feeding the spreader
`timescale 1ns/1ps
`default_nettype none
`include "lts_consts.svh"
module lts_framer #(
    parameter int        TEL_LEN   = 1100,
    parameter int        CHIP_LEN  = `LTS_CHIP_LEN,
    parameter logic [7:0] FILL_LEN = `LTS_FILL_DEFAULT
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                tel_bit_valid,
    input  wire logic                tel_bit,
    input  wire logic                tel_switch,
    output logic                     tel_bit_ready,
    input  wire logic                fill_level,
    input  wire logic [3:0]          spreading_code_number,
    input  wire logic                test_enable,
    input  wire logic [CHIP_LEN-1:0] code_chips,
    output logic [3:0]               code_in_use_ff,
    output logic                     code_rejected_ff,
    output logic                     filling_ff,
    output logic                     chip_out_ff,
    output logic                     chip_valid_ff,
    output logic                     bit_start_ff
);
    // filler length clamped into the legal window
    localparam logic [7:0] FILL_USE = (FILL_LEN < `LTS_FILL_MIN) ? `LTS_FILL_MIN :
                                      (FILL_LEN > `LTS_FILL_MAX) ? `LTS_FILL_MAX : FILL_LEN; // [R3]
    lts_chip_if cif();
    lts_pkg::lts_state_t state_ff;
    logic [7:0] fill_cnt_ff;
    logic       fill_val_ff;
    logic       code_ok;

    assign code_ok = (spreading_code_number <= `LTS_CODE_LAST_OP) ||
                     (test_enable && spreading_code_number == `LTS_CODE_TEST); // [R5] [R6]
    // source bits pass one for one, no rate change or buffering
    assign tel_bit_ready = (state_ff == lts_pkg::LTS_TELEGRAM) && cif.bit_ready && !tel_switch; // [R9]
    // on the switch edge the first filler bit is offered, so the chip stream has no gap
    assign cif.bit_valid = (state_ff == lts_pkg::LTS_TELEGRAM) ? (tel_switch ? code_ok : tel_bit_valid) : // [R9]
                           (state_ff == lts_pkg::LTS_FILL);
    assign cif.bit_value = (state_ff == lts_pkg::LTS_FILL) ? fill_val_ff :
                           (tel_switch ? fill_level : tel_bit); // [R2]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff    <= lts_pkg::LTS_IDLE;
            fill_cnt_ff <= 8'h00;
            fill_val_ff <= 1'b0;
        end else begin
            case (state_ff)
                lts_pkg::LTS_IDLE: begin
                    if (code_ok) begin
                        state_ff <= lts_pkg::LTS_TELEGRAM;
                    end
                end
                lts_pkg::LTS_TELEGRAM: begin
                    if (!code_ok) begin
                        state_ff <= lts_pkg::LTS_IDLE;
                    end else if (tel_switch) begin
                        // switch taken at whatever bit is current
                        state_ff    <= lts_pkg::LTS_FILL; // [R2] [R4]
                        // a filler bit taken on this edge already counts
                        fill_cnt_ff <= cif.bit_ready ? 8'h01 : 8'h00; // [R3]
                        fill_val_ff <= fill_level;
                    end
                    // otherwise keep relaying the repeating source stream [R1]
                end
                lts_pkg::LTS_FILL: begin
                    if (cif.bit_ready) begin
                        if (fill_cnt_ff == FILL_USE - 8'h01) begin
                            state_ff <= lts_pkg::LTS_TELEGRAM; // [R3]
                        end else begin
                            fill_cnt_ff <= fill_cnt_ff + 8'h01;
                        end
                    end
                end
                default: state_ff <= lts_pkg::LTS_IDLE;
            endcase
        end
    end

    // code latched only while idle so it stays fixed during a transmission
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code_in_use_ff   <= 4'h0;
            code_rejected_ff <= 1'b0;
        end else begin
            code_rejected_ff <= !code_ok; // [R6]
            if (state_ff == lts_pkg::LTS_IDLE && code_ok) begin
                code_in_use_ff <= spreading_code_number; // [R10]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filling_ff <= 1'b0;
        end else begin
            filling_ff <= (state_ff == lts_pkg::LTS_FILL);
        end
    end

    lts_spreader #(
        .CHIP_LEN(CHIP_LEN)
    ) u_spreader (
        .clk          (clk),
        .rst_n        (rst_n),
        .cif          (cif),
        .code_chips   (code_chips),
        .chip_out_ff  (chip_out_ff),
        .chip_valid_ff(chip_valid_ff),
        .bit_start_ff (bit_start_ff)
    );
endmodule
`default_nettype wire

// file: lts_properties.sv
// port assertions for the framer
`timescale 1ns/1ps
`default_nettype none
`include "lts_consts.svh"
module lts_properties #(parameter int CHIP_LEN = `LTS_CHIP_LEN) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       tel_bit_valid,
    input wire logic       tel_switch,
    input wire logic       tel_bit_ready,
    input wire logic       test_enable,
    input wire logic [3:0] code_in_use_ff,
    input wire logic       filling_ff,
    input wire logic       chip_out_ff,
    input wire logic       chip_valid_ff,
    input wire logic       bit_start_ff
);
    logic [9:0] cnt_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) cnt_ff <= '0;
        else if (!chip_valid_ff) cnt_ff <= '0;
        else if (bit_start_ff) cnt_ff <= 10'h1;
        else cnt_ff <= cnt_ff + 10'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_take; tel_bit_valid && tel_bit_ready; endsequence
    sequence s_start; ##2 bit_start_ff; endsequence
    a_take_to_start: assert property (s_take |-> s_start) else $error("no bit start after take");
    a_pass_length: assert property (chip_valid_ff |-> (bit_start_ff ? (cnt_ff == 0 || cnt_ff == CHIP_LEN)
        : (cnt_ff > 0 && cnt_ff < CHIP_LEN))) else $error("chip pass length wrong");
    a_code_stable: assert property (chip_valid_ff && $past(chip_valid_ff) |-> $stable(code_in_use_ff))
        else $error("code number moved");
    a_no_test_code: assert property (chip_valid_ff && !test_enable |-> code_in_use_ff != 4'hf)
        else $error("test code sent");
    a_switch_holds: assert property (tel_switch |-> !tel_bit_ready) else $error("bit taken in switch");
    a_switch_fill: assert property ($rose(tel_switch) && chip_valid_ff && !filling_ff |-> ##[1:3] filling_ff)
        else $error("no filler after switch");
    a_idle_zero: assert property (!chip_valid_ff |-> !chip_out_ff) else $error("chip while idle");
    a_repeat_on: assert property (chip_valid_ff && tel_bit_valid |-> ##1 chip_valid_ff)
        else $error("stream stopped");
endmodule
bind lts_framer lts_properties #(.CHIP_LEN(CHIP_LEN)) i_lts_properties(.clk, .rst_n, .tel_bit_valid,
    .tel_switch, .tel_bit_ready, .test_enable, .code_in_use_ff, .filling_ff, .chip_out_ff, .chip_valid_ff,
    .bit_start_ff);
`default_nettype wire

// file: lts_loop_rx.sv
// on-board receiver model: despreads with its own code
`timescale 1ns/1ps
`default_nettype none
module lts_loop_rx #(parameter int CHIP_LEN = 8) (
    input wire logic                clk,
    input wire logic                rst_n,
    input wire logic                chip_out_ff,
    input wire logic                chip_valid_ff,
    input wire logic                bit_start_ff,
    input wire logic [CHIP_LEN-1:0] code_chips,
    output logic                    rx_strobe,
    output logic                    rx_bit,
    output logic                    rx_bad
);
    logic [9:0] idx_ff;
    logic       cur_ff;
    wire  [9:0] i = bit_start_ff ? 10'h0 : idx_ff;
    wire        b = chip_out_ff ^ code_chips[i];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {idx_ff, cur_ff, rx_bad, rx_strobe, rx_bit} <= '0;
        end else begin
            rx_strobe <= 1'b0;
            if (chip_valid_ff) begin
                idx_ff <= i + 10'h1;
                if (bit_start_ff) cur_ff <= b;
                else if (b != cur_ff) rx_bad <= 1'b1;
                if (i == CHIP_LEN - 1) begin
                    rx_strobe <= 1'b1;
                    rx_bit <= b;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: lts_framer_tb.sv
// self-checking bench for the framer
`timescale 1ns/1ps
`default_nettype none
module lts_framer_tb;
    localparam int CL = 8;
    localparam logic [7:0] FL = 8'h4b;
    logic clk = 0, rst_n = 0, tel_bit_valid = 0, tel_switch = 0, fill_level = 0, test_enable = 0;
    logic [3:0] spreading_code_number = 4'hf;
    logic [CL-1:0] code_chips = 8'hb4;
    logic [7:0] tel = 8'h5a, run = 0, maxrun = 0;
    logic [2:0] pos = 0;
    logic [15:0] rxq = 0;
    logic tel_bit_ready, code_rejected_ff, filling_ff, chip_out_ff, chip_valid_ff, bit_start_ff;
    logic rx_strobe, rx_bit, rx_bad, alien_bad;
    logic [3:0] code_in_use_ff;
    int nrx = 0, cyc = 0, miscompares = 0, tests_run = 0;
    wire tel_bit = tel[pos];
    lts_framer #(.CHIP_LEN(CL), .FILL_LEN(FL)) i_lts_framer(.clk, .rst_n, .tel_bit_valid, .tel_bit, .tel_switch,
        .tel_bit_ready, .fill_level, .spreading_code_number, .test_enable, .code_chips, .code_in_use_ff,
        .code_rejected_ff, .filling_ff, .chip_out_ff, .chip_valid_ff, .bit_start_ff);
    lts_loop_rx #(.CHIP_LEN(CL)) i_lts_loop_rx(.clk, .rst_n, .chip_out_ff, .chip_valid_ff, .bit_start_ff,
        .code_chips, .rx_strobe, .rx_bit, .rx_bad);
    // second receiver set to another code: it must not see a clean message
    lts_loop_rx #(.CHIP_LEN(CL)) i_lts_loop_rx_foreign(.clk, .rst_n, .chip_out_ff, .chip_valid_ff, .bit_start_ff,
        .code_chips(8'h1e), .rx_strobe(), .rx_bit(), .rx_bad(alien_bad));
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        if (tel_bit_valid && tel_bit_ready) pos <= pos + 3'h1;
        if (rx_strobe) begin
            rxq <= {rxq[14:0], rx_bit};
            nrx <= nrx + 1;
            run <= rx_bit ? run + 8'h1 : 8'h0;
            if (rx_bit && run >= maxrun) maxrun <= run + 8'h1;
        end
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        tests_run++;
        if (e !== g) begin
            $display("BAD %s exp %h got %h", n, e, g);
            miscompares++;
        end
    endtask
    task automatic t_code15();
        repeat (20) @(posedge clk);
        chk("rejected", 16'h1, {15'h0, code_rejected_ff});
        chk("valid", 16'h0, {15'h0, chip_valid_ff});
        test_enable <= 1'b1;
        repeat (4) @(posedge clk);
        chk("test accepted", 16'h0, {15'h0, code_rejected_ff});
        chk("test code", 16'hf, {12'h0, code_in_use_ff});
        test_enable <= 1'b0;
        repeat (4) @(posedge clk);
        chk("test revoked", 16'h1, {15'h0, code_rejected_ff});
        spreading_code_number <= 4'h3;
        tel_bit_valid <= 1'b1;
    endtask
    task automatic t_repeat();
        while (nrx < 16) @(posedge clk);
        chk("bits", 16'h5a5a, rxq);
        chk("code", 16'h3, {12'h0, code_in_use_ff});
        chk("foreign code", 16'h1, {15'h0, alien_bad});
    endtask
    task automatic t_switch();
        @(posedge clk);
        fill_level <= 1'b1;
        tel_switch <= 1'b1;
        tel <= 8'h00;
        @(posedge clk);
        tel_switch <= 1'b0;
        while (nrx < 16 + FL + 24) @(posedge clk);
        chk("fill run", 16'h1, {15'h0, maxrun >= FL && maxrun <= FL + 8'h2});
        chk("new tel", 16'h0, rxq);
        chk("despread", 16'h0, {15'h0, rx_bad});
    endtask
    task automatic conclude();
        $display("checks %0d bad %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_code15();
        t_repeat();
        t_switch();
        conclude();
    end
endmodule
`default_nettype wire
